// >>> common/cps_pkg.sv
/*
 Package for the capacitive proximity sequencer: field widths, state codes,
 reset values and the packed settings and results structs.
 Assumes a single 40 MHz clock domain.
*/
`default_nettype none
package cps_pkg;
	// ============================================================
	// Widths
	localparam int SAMPLE_W = 12;
	localparam int PERIOD_W = 8;
	localparam int COEF_W = 4;
	localparam int DELTA_W = 13;
	localparam int RATE_W = 8;
	localparam int STUCK_W = 8;
	localparam int DRIFT_W = 12;
	localparam int SCAN_TICK_W = 16;
	localparam int CLOCK_MHZ = 40;
	localparam int SCAN_UNIT_US = 1000;
	localparam int SCAN_UNIT_CYC = SCAN_UNIT_US * CLOCK_MHZ;
	// ============================================================
	// Reset values
	localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 12'h000;
	localparam logic [DELTA_W-1:0] DELTA_RST = 13'h0000;
	// ============================================================
	// Pin select codes
	localparam logic SENSOR_SEL_SCREEN = 1'b0;
	localparam logic SENSOR_SEL_EXT = 1'b1;
	localparam logic SHIELD_SEL_SCREEN = 1'b0;
	localparam logic SHIELD_SEL_EXT = 1'b1;
	// ============================================================
	// Sequencer states
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADC_REQ = 7'h02,
		ST_COMP = 7'h04,
		ST_MEAS = 7'h08,
		ST_FILT = 7'h10,
		ST_BASE = 7'h20,
		ST_DELTA = 7'h40
	} cps_state_type;
	// ============================================================
	// Host settings
	typedef struct packed {
		logic [PERIOD_W-1:0] scanPeriodSetting;
		logic sensorPinSelect;
		logic shieldPinSelect;
		logic [2:0] sensitivitySetting;
		logic sensitivityBoost;
		logic [2:0] excitationFrequency;
		logic highNoiseImmunity;
		logic [COEF_W-1:0] rawFilterCoefficient;
		logic [COEF_W-1:0] baselineCoefficient;
		logic [DELTA_W-1:0] proximityThreshold;
		logic [DRIFT_W-1:0] driftLimit;
		logic [RATE_W-1:0] periodicCompensationRate;
		logic [STUCK_W-1:0] stuckCloseTimeout;
	} cps_settings_type;
	// Processing results
	typedef struct packed {
		logic [SAMPLE_W-1:0] rawCapacitanceSample;
		logic [SAMPLE_W-1:0] filteredSample;
		logic [SAMPLE_W-1:0] environmentBaseline;
		logic [DELTA_W-1:0] userDelta;
		logic proximityCloseFlag;
	} cps_results_type;
endpackage
`default_nettype wire

// >>> dv/cps_afe_model.sv
/*
 Front-end and shared converter model.
 Assumes the sequencer holds its request until the scan ends.
*/
`timescale 1ns/1ps
`default_nettype none
module cps_afe_model
	import cps_pkg::*;
(
	// Clock, reset and pacing
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic [SAMPLE_W-1:0] level,
	// Converter slot
	input wire logic adcRequest,
	output logic adcGrant,
	// Front-end
	input wire logic afeStart,
	output logic afeReady,
	output logic [SAMPLE_W-1:0] afeSample
);
	logic [3:0] slotQ;
	logic [3:0] busyQ;
	// ============================================================
	// Slot granted after touch work, held until released
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			slotQ <= 4'h0;
			adcGrant <= 1'b0;
		end
		else if (!adcRequest)
		begin
			slotQ <= slow ? 4'h9 : 4'h2;
			adcGrant <= 1'b0;
		end
		else if (slotQ != 4'h0)
			slotQ <= slotQ - 4'h1;
		else
			adcGrant <= 1'b1;
	end
	// Sample valid only with ready, otherwise toggling
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busyQ <= 4'h0;
			afeReady <= 1'b0;
			afeSample <= 12'h000;
		end
		else
		begin
			afeReady <= busyQ == 4'h1;
			afeSample <= (busyQ == 4'h1) ? level : ~afeSample;
			if (afeStart)
				busyQ <= slow ? 4'hc : 4'h3;
			else if (busyQ != 4'h0)
				busyQ <= busyQ - 4'h1;
		end
	end
endmodule // cps_afe_model
`default_nettype wire

// >>> dv/cps_sequencer_sva.sv
/*
 Checker for the proximity sequencer, bound to its ports.
 Assumes one clock domain and settings held steady during a scan.
*/
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer_sva
	import cps_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Watched ports
	input wire cps_settings_type settings,
	input wire logic adcRequest,
	input wire logic adcGrant,
	input wire logic afeStart,
	input wire logic afeCompensate,
	input wire logic sensorOnExtPin,
	input wire logic shieldOnExtPin,
	input wire cps_results_type results,
	input wire logic conversionActiveFlag,
	input wire logic compensationPendingFlag,
	input wire logic scanDone
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ============================================================
	// Properties
	AST_NO_SCAN: assert property (settings.scanPeriodSetting == 8'h00 && !adcRequest |=> !adcRequest)
		else $error("scan started with zero period");
	AST_START: assert property ($rose(adcGrant) && adcRequest |=> afeStart)
		else $error("front-end not started after grant");
	AST_COMP_START: assert property ($rose(afeCompensate) |-> afeStart && $past(adcGrant))
		else $error("compensation outside scan start");
	AST_PEND_HOLD: assert property (compensationPendingFlag && !afeCompensate |=> compensationPendingFlag)
		else $error("pending flag dropped early");
	AST_PEND_CLEAR: assert property ($fell(compensationPendingFlag) |-> afeStart && afeCompensate)
		else $error("pending flag cleared outside compensation");
	AST_DONE: assert property ($fell(adcRequest) |-> scanDone)
		else $error("scan ended without done pulse");
	AST_CLOSE: assert property (scanDone |-> results.proximityCloseFlag ==
		($signed(results.userDelta) > $signed(settings.proximityThreshold)))
		else $error("close flag wrong");
	AST_DELTA: assert property (scanDone |-> results.userDelta ==
		({1'b0, results.filteredSample} - {1'b0, results.environmentBaseline}))
		else $error("delta wrong");
	AST_ROUTE: assert property (adcRequest && $past(adcRequest) |->
		sensorOnExtPin == settings.sensorPinSelect && shieldOnExtPin == settings.shieldPinSelect)
		else $error("electrode routing wrong");
	AST_CONV: assert property (afeStart |-> conversionActiveFlag ##1 conversionActiveFlag)
		else $error("conversion flag low in operation");
endmodule // cps_sequencer_sva
bind cps_sequencer cps_sequencer_sva u_sva (.mclk(mclk), .reset_n(reset_n), .settings(settings),
	.adcRequest(adcRequest), .adcGrant(adcGrant), .afeStart(afeStart),
	.afeCompensate(afeCompensate), .sensorOnExtPin(sensorOnExtPin),
	.shieldOnExtPin(shieldOnExtPin), .results(results),
	.conversionActiveFlag(conversionActiveFlag),
	.compensationPendingFlag(compensationPendingFlag), .scanDone(scanDone));
`default_nettype wire

// >>> dv/cps_sequencer_tb.sv
/*
 Testbench for the proximity sequencer with the front-end model.
 Assumes a short scan unit so that scans take tens of cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer_tb
	import cps_pkg::*;
;
	logic mclk, reset_n, hostReq, slow;
	logic afeBoost, sensScr, sensExt, shldScr, shldExt;
	logic [2:0] afeSens, afeFreq;
	logic adcRequest, adcGrant, afeStart, afeCompensate, afeReady, afeHighImmunity;
	logic conversionActiveFlag, compensationPendingFlag, scanDone;
	logic [SAMPLE_W-1:0] level, afeSample;
	cps_settings_type cfg;
	cps_results_type results;
	int failures = 0, checks_done = 0, reqCnt = 0, compCnt = 0, n, m;
	cps_sequencer #(.SCAN_UNIT(4)) dut (.mclk(mclk), .reset_n(reset_n), .settings(cfg),
		.hostCompRequest(hostReq), .adcRequest(adcRequest), .adcGrant(adcGrant),
		.afeStart(afeStart), .afeCompensate(afeCompensate), .afeHighImmunity(afeHighImmunity),
		.afeBoost(afeBoost), .afeSensitivity(afeSens), .afeFrequency(afeFreq),
		.afeReady(afeReady), .afeSample(afeSample), .sensorOnScreen(sensScr),
		.sensorOnExtPin(sensExt), .shieldOnScreen(shldScr), .shieldOnExtPin(shldExt),
		.results(results), .conversionActiveFlag(conversionActiveFlag),
		.compensationPendingFlag(compensationPendingFlag), .scanDone(scanDone));
	cps_afe_model u_afe (.mclk(mclk), .reset_n(reset_n), .slow(slow), .level(level),
		.adcRequest(adcRequest), .adcGrant(adcGrant), .afeStart(afeStart),
		.afeReady(afeReady), .afeSample(afeSample));
	// ============================================================
	// Clock, monitors and tasks
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		if (afeCompensate === 1'b1)
			compCnt <= compCnt + 1;
		if (adcRequest === 1'b1)
			reqCnt <= reqCnt + 1;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#2;
	endtask
	task automatic wait_scan();
		int i;
		i = 0;
		// Always pass one edge so a done pulse is never counted twice
		do
		begin
			@(posedge mclk);
			#2;
			i++;
		end
		while (scanDone !== 1'b1 && i < 400);
		check("scanDone", 16'(scanDone), 16'h0001);
	endtask
	task automatic chk_res(input logic [11:0] r, f, b, input logic [12:0] d, input logic c);
		check("raw", 16'(results.rawCapacitanceSample), 16'(r));
		check("filtered", 16'(results.filteredSample), 16'(f));
		check("baseline", 16'(results.environmentBaseline), 16'(b));
		check("delta", 16'(results.userDelta), 16'(d));
		check("close", 16'(results.proximityCloseFlag), 16'(c));
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#500000;
		failures++;
		$display("unexpected run expected done seen hang");
		finish_test();
	end
	// ============================================================
	// Tests
	initial
	begin
		cfg = '0;
		cfg.sensorPinSelect = 1'b1;
		cfg.sensitivityBoost = 1'b1;
		cfg.excitationFrequency = 3'h7;
		cfg.highNoiseImmunity = 1'b1;
		cfg.rawFilterCoefficient = 4'h8;
		cfg.baselineCoefficient = 4'h8;
		cfg.proximityThreshold = 13'h0040;
		cfg.sensitivitySetting = 3'h1;
		hostReq = 1'b0;
		slow = 1'b0;
		level = 12'h100;
		reset_n = 1'b0;
		step(2);
		reset_n = 1'b1;
		step(100);
		check("adcRequest", 16'(adcRequest), 16'h0000);
		check("afeHighImmunity", 16'(afeHighImmunity), 16'h0001);
		check("afeBoost", 16'(afeBoost), 16'h0001);
		check("afeSensitivity", 16'(afeSens), 16'h0001);
		check("afeFrequency", 16'(afeFreq), 16'h0007);
		check("route", 16'({sensScr, sensExt, shldScr, shldExt}), 16'h0000);
		$display("test idle done");
		cfg.scanPeriodSetting = 8'h04;
		step(2);
		check("pending", 16'(compensationPendingFlag), 16'h0001);
		wait_scan();
		check("compensate", 16'(compCnt != 0), 16'h0001);
		check("pending", 16'(compensationPendingFlag), 16'h0000);
		check("route", 16'({sensScr, sensExt, shldScr, shldExt}), 16'h0006);
		chk_res(12'h100, 12'h100, 12'h100, 13'h0000, 1'b0);
		level = 12'h300;
		m = compCnt;
		wait_scan();
		chk_res(12'h300, 12'h200, 12'h180, 13'h0080, 1'b1);
		wait_scan();
		chk_res(12'h300, 12'h280, 12'h180, 13'h0100, 1'b1);
		level = 12'h100;
		slow = 1'b1;
		cfg.sensorPinSelect = 1'b0;
		cfg.shieldPinSelect = 1'b1;
		wait_scan();
		chk_res(12'h100, 12'h1c0, 12'h180, 13'h0040, 1'b0);
		check("route", 16'({sensScr, sensExt, shldScr, shldExt}), 16'h0009);
		check("afeBoost", 16'(afeBoost), 16'h0000);
		slow = 1'b0;
		wait_scan();
		chk_res(12'h100, 12'h160, 12'h170, 13'h1ff0, 1'b0);
		check("compensate", 16'(compCnt - m), 16'h0000);
		$display("test processing done");
		m = compCnt;
		hostReq = 1'b1;
		step(1);
		hostReq = 1'b0;
		check("pending", 16'(compensationPendingFlag), 16'h0001);
		wait_scan();
		check("compensate", 16'(compCnt != m), 16'h0001);
		chk_res(12'h100, 12'h100, 12'h100, 13'h0000, 1'b0);
		cfg.periodicCompensationRate = 8'h01;
		wait_scan();
		step(1);
		check("pending", 16'(compensationPendingFlag), 16'h0001);
		cfg.periodicCompensationRate = 8'h00;
		level = 12'h300;
		cfg.stuckCloseTimeout = 8'h01;
		wait_scan();
		chk_res(12'h300, 12'h300, 12'h300, 13'h0000, 1'b0);
		level = 12'h500;
		wait_scan();
		chk_res(12'h500, 12'h400, 12'h380, 13'h0080, 1'b1);
		step(1);
		check("pending", 16'(compensationPendingFlag), 16'h0001);
		cfg.stuckCloseTimeout = 8'h00;
		cfg.driftLimit = 12'h040;
		wait_scan();
		step(1);
		check("pending", 16'(compensationPendingFlag), 16'h0000);
		level = 12'h100;
		wait_scan();
		chk_res(12'h100, 12'h300, 12'h400, 13'h1f00, 1'b0);
		step(1);
		check("pending", 16'(compensationPendingFlag), 16'h0001);
		cfg.driftLimit = 12'h000;
		$display("test compensation done");
		cfg.scanPeriodSetting = 8'h00;
		step(40);
		n = reqCnt;
		step(100);
		check("requests", 16'(reqCnt - n), 16'h0000);
		$display("test disable done");
		finish_test();
	end
endmodule // cps_sequencer_tb
`default_nettype wire

// >>> logic/cps_iir.sv
/*
 First-order recursive blend: out = (1-k)*newSample + k*previous, k = coef/16.
 Purely combinational; caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module cps_iir
	import cps_pkg::*;
(
	// Operands
	input wire logic [SAMPLE_W-1:0] newSample,
	input wire logic [SAMPLE_W-1:0] prevValue,
	input wire logic [COEF_W-1:0] coef,
	// Result
	output logic [SAMPLE_W-1:0] blended
);
	localparam logic [COEF_W:0] FULL = 5'h10;
	logic [SAMPLE_W+COEF_W:0] sum;
	logic [SAMPLE_W+COEF_W:0] newWide;
	logic [SAMPLE_W+COEF_W:0] prevWide;
	logic [SAMPLE_W+COEF_W:0] newWeight;
	logic [SAMPLE_W+COEF_W:0] prevWeight;
	// Operands widened first so the products cannot overflow
	always_comb
	begin
		newWide = {{(COEF_W+1){1'b0}}, newSample};
		prevWide = {{(COEF_W+1){1'b0}}, prevValue};
		newWeight = {{SAMPLE_W{1'b0}}, FULL - {1'b0, coef}};
		prevWeight = {{(SAMPLE_W+1){1'b0}}, coef};
		sum = newWide * newWeight + prevWide * prevWeight;
		blended = sum[SAMPLE_W+COEF_W-1:COEF_W];
	end
endmodule // cps_iir
`default_nettype wire

// >>> logic/cps_sequencer.sv
/*
 Capacitive proximity sequencer: scan timer, compensation request handling,
 shared ADC arbitration, front-end control and sample processing.
 Assumes the front-end and ADC arbiter run on mclk; the ADC grant holds
 until the request drops. afeReady is a one-cycle pulse from same domain.
*/
// How it works
// - Sleep in idle, wake each scan period for one sample.
// - Nonzero scan period after zero raises a compensation request.
// - Host compensation pulse is latched at any time.
// - Baseline drift beyond limit since last compensation requests one.
// - Periodic counter of scans requests compensation at programmed rate.
// - Close state lasting past stuck timeout requests compensation.
// - Pending flag stays set until compensation completes.
// - Compensation executes only at start of a scan.
// - Shared ADC requested and granted; 12-bit sample taken.
// - Raw, filtered, baseline, delta, close flag updated in order.
// - Conversion-active flag high during proximity operation.
// - Start front-end, wait ready; compensate first if pending.
// - Close flag is delta compared against host threshold.
// - Sensor select picks screen top layer or external sensor pin.
// - Shield select picks screen bottom layer or external shield pin.
// - Baseline tracks filtered sample slowly; removed to get delta.
// - Compensation measures environment once, subtracted before conversion.
// - High noise immunity setting forwarded to front-end mode.
// - Filtered = (1-k)*raw + k*previous filtered.
// - Delta equals filtered minus baseline.
// - Baseline frozen while close flag set, except on the first scan after a compensation.
// - Zero scan period performs no proximity operation.
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer
	import cps_pkg::*;
#(
	parameter int SCAN_UNIT = SCAN_UNIT_CYC
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Host settings and compensation request
	input wire cps_settings_type settings,
	input wire logic hostCompRequest,
	// Shared ADC arbitration
	output logic adcRequest,
	input wire logic adcGrant,
	// Analog front-end
	output logic afeStart,
	output logic afeCompensate,
	output logic afeHighImmunity,
	output logic afeBoost,
	output logic [2:0] afeSensitivity,
	output logic [2:0] afeFrequency,
	input wire logic afeReady,
	input wire logic [SAMPLE_W-1:0] afeSample,
	// Electrode routing
	output logic sensorOnScreen,
	output logic sensorOnExtPin,
	output logic shieldOnScreen,
	output logic shieldOnExtPin,
	// Status
	output cps_results_type results,
	output logic conversionActiveFlag,
	output logic compensationPendingFlag,
	output logic scanDone
);
	// ============================================================
	// Scan period timer
	cps_state_type state_q;
	logic [SCAN_TICK_W-1:0] unitCnt_q;
	logic [PERIOD_W-1:0] periodCnt_q;
	logic scanTick;
	logic enabled;
	logic enabledPrev_q;

	assign enabled = settings.scanPeriodSetting != '0;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			unitCnt_q <= '0;
			periodCnt_q <= '0;
			enabledPrev_q <= 1'b0;
		end
		else
		begin
			enabledPrev_q <= enabled;
			if (!enabled)
			begin
				unitCnt_q <= '0;
				periodCnt_q <= '0;
			end
			else if (unitCnt_q == SCAN_TICK_W'(SCAN_UNIT - 1))
			begin
				unitCnt_q <= '0;
				if (periodCnt_q >= settings.scanPeriodSetting - 8'h01)
					periodCnt_q <= '0;
				else
					periodCnt_q <= periodCnt_q + 8'h01;
			end
			else
				unitCnt_q <= unitCnt_q + 16'h0001;
		end
	end

	// Ticks arriving while busy are ignored
	assign scanTick = enabled && unitCnt_q == SCAN_TICK_W'(SCAN_UNIT - 1)
		&& periodCnt_q >= settings.scanPeriodSetting - 8'h01;

	// ============================================================
	// Compensation request sources
	logic [RATE_W-1:0] periodicCnt_q;
	logic [STUCK_W-1:0] stuckCnt_q;
	logic [SAMPLE_W-1:0] compBaseline_q;
	logic reqStartup;
	logic reqPeriodic;
	logic reqStuck;
	logic reqDrift;
	logic compDone;
	logic [SAMPLE_W:0] driftAbs;

	assign reqStartup = enabled && !enabledPrev_q;
	assign reqPeriodic = scanDone && settings.periodicCompensationRate != '0
		&& periodicCnt_q >= settings.periodicCompensationRate - 8'h01;
	assign reqStuck = scanDone && settings.stuckCloseTimeout != '0
		&& results.proximityCloseFlag
		&& stuckCnt_q >= settings.stuckCloseTimeout - 8'h01;
	assign driftAbs = (results.environmentBaseline >= compBaseline_q)
		? {1'b0, results.environmentBaseline - compBaseline_q}
		: {1'b0, compBaseline_q - results.environmentBaseline};
	assign reqDrift = scanDone && settings.driftLimit != '0
		&& driftAbs > {1'b0, settings.driftLimit};
	assign compDone = state_q == ST_COMP && afeReady;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			periodicCnt_q <= '0;
			stuckCnt_q <= '0;
		end
		else
		begin
			if (compDone || reqPeriodic)
				periodicCnt_q <= '0;
			else if (scanDone)
				periodicCnt_q <= periodicCnt_q + 8'h01;
			if (compDone || reqStuck || !results.proximityCloseFlag)
				stuckCnt_q <= '0;
			else if (scanDone)
				stuckCnt_q <= stuckCnt_q + 8'h01;
		end
	end

	// Set wins over the clear from a completing compensation
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			compensationPendingFlag <= 1'b0;
		else if (reqStartup || hostCompRequest || reqDrift || reqPeriodic
			|| reqStuck)
			compensationPendingFlag <= 1'b1;
		else if (compDone)
			compensationPendingFlag <= 1'b0;
		else if (!enabled)
			compensationPendingFlag <= compensationPendingFlag;
	end

	// ============================================================
	// Sequencer
	logic [SAMPLE_W-1:0] filtNext;
	logic [SAMPLE_W-1:0] baseNext;
	logic [DELTA_W-1:0] deltaNext;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			state_q <= ST_IDLE;
		else
		begin
			unique case (state_q)
				ST_IDLE:
					if (scanTick)
						state_q <= ST_ADC_REQ;
				ST_ADC_REQ:
					if (adcGrant)
						state_q <= compensationPendingFlag ? ST_COMP : ST_MEAS;
				ST_COMP:
					if (afeReady)
						state_q <= ST_MEAS;
				ST_MEAS:
					if (afeReady)
						state_q <= ST_FILT;
				ST_FILT:
					state_q <= ST_BASE;
				ST_BASE:
					state_q <= ST_DELTA;
				ST_DELTA:
					state_q <= ST_IDLE;
			endcase
		end
	end

	assign adcRequest = state_q != ST_IDLE;
	assign conversionActiveFlag = state_q != ST_IDLE;

	// Single-cycle start pulse on entry to each front-end phase
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			afeStart <= 1'b0;
			afeCompensate <= 1'b0;
		end
		else
		begin
			afeStart <= (state_q == ST_ADC_REQ && adcGrant)
				|| (state_q == ST_COMP && afeReady);
			if (state_q == ST_ADC_REQ && adcGrant)
				afeCompensate <= compensationPendingFlag;
			else if (state_q != ST_COMP)
				afeCompensate <= 1'b0;
		end
	end

	// Drift reference is the first baseline after a compensation
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			compBaseline_q <= SAMPLE_RST;
		else if (state_q == ST_DELTA && firstAfterComp_q)
			compBaseline_q <= results.environmentBaseline;
	end

	// ============================================================
	// Processing chain
	logic firstAfterComp_q;

	cps_iir u_rawFilter (
		.newSample(results.rawCapacitanceSample),
		.prevValue(results.filteredSample),
		.coef(settings.rawFilterCoefficient),
		.blended(filtNext)
	);

	cps_iir u_baseFilter (
		.newSample(results.filteredSample),
		.prevValue(results.environmentBaseline),
		.coef(settings.baselineCoefficient),
		.blended(baseNext)
	);

	assign deltaNext = DELTA_W'({1'b0, results.filteredSample})
		- DELTA_W'({1'b0, results.environmentBaseline});

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			results.rawCapacitanceSample <= SAMPLE_RST;
			results.filteredSample <= SAMPLE_RST;
			results.environmentBaseline <= SAMPLE_RST;
			results.userDelta <= DELTA_RST;
			results.proximityCloseFlag <= 1'b0;
			firstAfterComp_q <= 1'b1;
			scanDone <= 1'b0;
		end
		else
		begin
			scanDone <= state_q == ST_DELTA;
			if (state_q == ST_MEAS && afeReady)
				results.rawCapacitanceSample <= afeSample;
			if (state_q == ST_FILT)
			begin
				if (firstAfterComp_q)
					results.filteredSample <= results.rawCapacitanceSample;
				else
					results.filteredSample <= filtNext;
			end
			if (state_q == ST_BASE)
			begin
				if (firstAfterComp_q)
					results.environmentBaseline <= results.filteredSample;
				else if (!results.proximityCloseFlag)
					results.environmentBaseline <= baseNext;
			end
			if (state_q == ST_DELTA)
			begin
				results.userDelta <= deltaNext;
				results.proximityCloseFlag <= $signed(deltaNext)
					> $signed(settings.proximityThreshold);
				firstAfterComp_q <= 1'b0;
			end
			// Scan after a compensation restarts the filters
			if (compDone)
				firstAfterComp_q <= 1'b1;
		end
	end

	// ============================================================
	// Front-end configuration and electrode routing
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			afeHighImmunity <= 1'b0;
			afeBoost <= 1'b0;
			afeSensitivity <= 3'h0;
			afeFrequency <= 3'h0;
			sensorOnScreen <= 1'b0;
			sensorOnExtPin <= 1'b0;
			shieldOnScreen <= 1'b0;
			shieldOnExtPin <= 1'b0;
		end
		else
		begin
			afeHighImmunity <= settings.highNoiseImmunity;
			// Boost only acts with the external sensor selected
			afeBoost <= settings.sensitivityBoost
				&& settings.sensorPinSelect == SENSOR_SEL_EXT;
			afeSensitivity <= settings.sensitivitySetting;
			afeFrequency <= settings.excitationFrequency;
			sensorOnScreen <= adcRequest
				&& settings.sensorPinSelect == SENSOR_SEL_SCREEN;
			sensorOnExtPin <= adcRequest
				&& settings.sensorPinSelect == SENSOR_SEL_EXT;
			shieldOnScreen <= adcRequest
				&& settings.shieldPinSelect == SHIELD_SEL_SCREEN;
			shieldOnExtPin <= adcRequest
				&& settings.shieldPinSelect == SHIELD_SEL_EXT;
		end
	end
endmodule // cps_sequencer
`default_nettype wire
